// file: core/smtm_core.sv
// Speed-match detector with hysteresis, velocity limit and forced control mode.
// Assumes an AHB-Lite master on clk_sys; status inputs are asynchronous pins.
// Functional notes
// - Match asserted when command-minus-measured speed is within the window.
// - Window accepts 10 to 20000 r/min, clamped, used as threshold.
// - Inactive to active only below window minus 10 r/min.
// - Active to inactive only above window plus 10 r/min.
// - Detection runs only in velocity or torque control.
// - Speed-limit output equals match output in torque control.
// - Torque control needs a velocity limit; device drives the selected limit (vlim1 or vlim2) on speedLimitCmd.
// - Velocity limits reset to zero.
// - Device overrides host mode from operating status.
// - Trial run, retract, forced deceleration stop force position control.
// - Frequency analysis forces position, velocity or torque per analysis kind.
// - Torque control operates only at servo-on.
`default_nettype none
`include "smtm_cfg.svh"
module smtm_core #(
   parameter int SPW = 16
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [SPW-1:0] speedCmd,
   input wire logic [SPW-1:0] motorSpeed,
   input wire logic servoOn,
   input wire logic trialRun,
   input wire logic retracting,
   input wire logic forcedPosStop,
   input wire logic [2:0] analysisKind,
   output logic speed_match_out,
   output logic speedLimitOut,
   output logic [1:0] activeMode,
   output logic torqueEnable,
   output logic [SPW-1:0] speedLimitCmd,
   output logic irq
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [8:0] syncA;
   logic [8:0] syncB;
   logic [SPW-1:0] spdA;
   logic [SPW-1:0] spdB;
   logic [SPW-1:0] cmdA;
   logic [SPW-1:0] cmdB;
   // Multi-bit speeds assumed held stable over several cycles by the source
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= '0;
         syncB <= '0;
         spdA <= '0;
         spdB <= '0;
         cmdA <= '0;
         cmdB <= '0;
      end else if (clkEn) begin
         syncA <= {servoOn, trialRun, retracting, forcedPosStop, analysisKind, 2'b00};
         syncB <= syncA;
         spdA <= motorSpeed;
         spdB <= spdA;
         cmdA <= speedCmd;
         cmdB <= cmdA;
      end
   end
   logic sOn;
   logic sTrial;
   logic sRetr;
   logic sFStop;
   logic [2:0] sAna;
   assign sOn = syncB[8];
   assign sTrial = syncB[7];
   assign sRetr = syncB[6];
   assign sFStop = syncB[5];
   assign sAna = syncB[4:2];

   // ************************************************************
   // Registers
   // ************************************************************
   logic [1:0] hostMode;
   logic slSel;
   logic [15:0] window;
   logic [15:0] vlim1;
   logic [15:0] vlim2;
   logic [1:0] irqStat;
   logic [1:0] irqMask;
   logic [15:0] torqueCmd;
   logic trqFresh;
   logic wrPend;
   logic rdPend;
   logic [11:0] addrQ;
   logic setMatchEv;
   logic setTrqEv;
   logic rdIrq;
   logic accept;
   assign accept = hsel && hready && htrans == `SMTM_HTRANS_NONSEQ;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         addrQ <= '0;
      end else if (clkEn) begin
         wrPend <= accept && hwrite;
         rdPend <= accept && !hwrite;
         if (accept) begin
            addrQ <= haddr;
         end
      end
   end

   function automatic logic [15:0] clampWin(input logic [15:0] v);
      if (v < `SMTM_WIN_MIN) begin
         clampWin = `SMTM_WIN_MIN;
      end else if (v > `SMTM_WIN_MAX) begin
         clampWin = `SMTM_WIN_MAX;
      end else begin
         clampWin = v;
      end
   endfunction

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hostMode <= 2'b01;
         slSel <= 1'b0;
         window <= `SMTM_WIN_RST;
         vlim1 <= `SMTM_VLIM_RST;
         vlim2 <= `SMTM_VLIM_RST;
         torqueCmd <= '0;
      end else if (clkEn && wrPend) begin
         if (addrQ == `SMTM_OFF_CTRL) begin
            hostMode <= hwdata[1:0];
            slSel <= hwdata[4];
         end else if (addrQ == `SMTM_OFF_WIN) begin
            window <= clampWin(hwdata[15:0]);
         end else if (addrQ == `SMTM_OFF_VLIM1) begin
            vlim1 <= (hwdata[15:0] > `SMTM_WIN_MAX) ? `SMTM_WIN_MAX : hwdata[15:0];
         end else if (addrQ == `SMTM_OFF_VLIM2) begin
            vlim2 <= (hwdata[15:0] > `SMTM_WIN_MAX) ? `SMTM_WIN_MAX : hwdata[15:0];
         end else if (addrQ == `SMTM_OFF_TRQ) begin
            torqueCmd <= hwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irqMask <= '0;
      end else if (clkEn && wrPend && addrQ == `SMTM_OFF_IRQMSK) begin
         irqMask <= hwdata[1:0];
      end
   end

   // ************************************************************
   // Forced control mode
   // ************************************************************
   smtm_pkg::smtm_mode_t next_mode;
   always_comb begin
      next_mode = smtm_pkg::smtm_mode_t'(hostMode);
      if (hostMode == 2'b11) begin
         next_mode = smtm_pkg::MODE_POS;
      end
      if (sTrial || sRetr || sFStop) begin
         next_mode = smtm_pkg::MODE_POS;
      end else if (sAna != 3'd0) begin
         case (sAna)
            3'd1: next_mode = smtm_pkg::MODE_POS;
            3'd2: next_mode = smtm_pkg::MODE_VEL;
            3'd3: next_mode = smtm_pkg::MODE_POS;
            3'd4: next_mode = smtm_pkg::MODE_VEL;
            3'd5: next_mode = smtm_pkg::MODE_TRQ;
            // Unused analysis codes keep the host choice, already mapped above
            default: next_mode = next_mode;
         endcase
      end
   end

   logic inTrq;
   assign inTrq = activeMode == smtm_pkg::MODE_TRQ;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         activeMode <= smtm_pkg::MODE_POS;
         torqueEnable <= 1'b0;
         speedLimitCmd <= '0;
      end else if (clkEn) begin
         activeMode <= next_mode;
         torqueEnable <= inTrq && sOn;
         speedLimitCmd <= (slSel ? vlim2 : vlim1);
      end
   end

   // ************************************************************
   // Speed match with hysteresis
   // ************************************************************
   logic signed [SPW:0] diff;
   logic [SPW:0] absDiff;
   logic [SPW:0] onThr;
   logic [SPW:0] offThr;
   logic detOn;
   assign diff = $signed({cmdB[SPW-1], cmdB}) - $signed({spdB[SPW-1], spdB});
   assign absDiff = diff[SPW] ? (SPW+1)'(-diff) : diff;
   assign onThr = (SPW+1)'(window - `SMTM_HYST);
   assign offThr = (SPW+1)'(window + `SMTM_HYST);
   assign detOn = activeMode == smtm_pkg::MODE_VEL || inTrq;

   logic next_match;
   always_comb begin
      next_match = speed_match_out;
      if (!detOn) begin
         next_match = 1'b0;
      end else if (!speed_match_out && absDiff < onThr) begin
         next_match = 1'b1;
      end else if (speed_match_out && absDiff > offThr) begin
         next_match = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         speed_match_out <= 1'b0;
         speedLimitOut <= 1'b0;
      end else if (clkEn) begin
         speed_match_out <= next_match;
         // Gated by the mode being loaded now, so limit and match switch together
         speedLimitOut <= next_match && next_mode == smtm_pkg::MODE_TRQ;
      end
   end

   // ************************************************************
   // Events and interrupt
   // ************************************************************
   logic matchQ;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         matchQ <= 1'b0;
         trqFresh <= 1'b0;
      end else if (clkEn) begin
         matchQ <= speed_match_out;
         // Torque command expected each cycle; flag shows a fresh one arrived
         if (wrPend && addrQ == `SMTM_OFF_TRQ) begin
            trqFresh <= 1'b1;
         end else if (rdPend && addrQ == `SMTM_OFF_STAT) begin
            trqFresh <= 1'b0;
         end
      end
   end
   assign setMatchEv = speed_match_out != matchQ;
   assign setTrqEv = wrPend && addrQ == `SMTM_OFF_TRQ;
   assign rdIrq = rdPend && addrQ == `SMTM_OFF_IRQST;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irqStat <= '0;
         irq <= 1'b0;
      end else if (clkEn) begin
         // Set beats the read-clear in the same cycle
         irqStat[0] <= setMatchEv | (irqStat[0] & ~rdIrq);
         irqStat[1] <= setTrqEv | (irqStat[1] & ~rdIrq);
         irq <= |(irqStat & irqMask);
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   logic [31:0] next_rdata;
   // Decoded from the address phase, so data stands through the data phase
   always_comb begin
      next_rdata = '0;
      if (haddr == `SMTM_OFF_CTRL) begin
         next_rdata = {27'h0, slSel, 2'b00, hostMode};
      end else if (haddr == `SMTM_OFF_WIN) begin
         next_rdata = {16'h0, window};
      end else if (haddr == `SMTM_OFF_VLIM1) begin
         next_rdata = {16'h0, vlim1};
      end else if (haddr == `SMTM_OFF_VLIM2) begin
         next_rdata = {16'h0, vlim2};
      end else if (haddr == `SMTM_OFF_STAT) begin
         next_rdata = {26'h0, trqFresh, torqueEnable, speedLimitOut, speed_match_out,
            activeMode};
      end else if (haddr == `SMTM_OFF_IRQST) begin
         next_rdata = {30'h0, irqStat};
      end else if (haddr == `SMTM_OFF_IRQMSK) begin
         next_rdata = {30'h0, irqMask};
      end else if (haddr == `SMTM_OFF_TRQ) begin
         next_rdata = {16'h0, torqueCmd};
      end
   end

   // Zero-wait slave: data phase completes in one cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (clkEn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (accept && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end
endmodule // smtm_core
`default_nettype wire

// file: core/smtm_cfg.svh
// Constants for the speed-match and torque-mode block.
// Assumes speeds are signed r/min integers on the sampled inputs.
`ifndef SMTM_CFG_SVH
`define SMTM_CFG_SVH
`define SMTM_HYST 16'h000a
`define SMTM_WIN_MIN 16'h000a
`define SMTM_WIN_MAX 16'h4e20
`define SMTM_WIN_RST 16'h000a
`define SMTM_VLIM_RST 16'h0000
`define SMTM_OFF_CTRL 12'h000
`define SMTM_OFF_WIN 12'h004
`define SMTM_OFF_VLIM1 12'h008
`define SMTM_OFF_VLIM2 12'h00c
`define SMTM_OFF_STAT 12'h010
`define SMTM_OFF_IRQST 12'h014
`define SMTM_OFF_IRQMSK 12'h018
`define SMTM_OFF_TRQ 12'h01c
`define SMTM_HTRANS_NONSEQ 2'b10
`endif

// file: core/smtm_pkg.sv
// Types for the speed-match and torque-mode block.
// Assumes nothing of its surroundings.
`default_nettype none
package smtm_pkg;
   typedef enum logic [1:0] {
      MODE_POS = 2'b00,
      MODE_VEL = 2'b01,
      MODE_TRQ = 2'b10
   } smtm_mode_t;
endpackage
`default_nettype wire

// file: verif/smtm_plant.sv
// Motor and command source facing the speed-match block.
// Assumes the bench sets the wanted speeds; values move on the clock.
`default_nettype none
module smtm_plant (
   input wire logic clk_sys,
   input wire logic [15:0] cmdSet,
   input wire logic [15:0] motSet,
   output logic [15:0] speedCmd,
   output logic [15:0] motorSpeed
);
   timeunit 1ns;
   timeprecision 1ps;
   // Command is re-sent every cycle, as the host does per link cycle
   always_ff @(posedge clk_sys) begin
      speedCmd <= cmdSet;
      motorSpeed <= motSet;
   end
endmodule // smtm_plant
`default_nettype wire

// file: verif/smtm_core_chk.sv
// Port checker for the speed-match and torque-mode block.
// Assumes bind to smtm_core; pins settle in at most 3 cycles.
`default_nettype none
module smtm_core_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic speed_match_out,
   input wire logic speedLimitOut,
   input wire logic [1:0] activeMode,
   input wire logic torqueEnable,
   input wire logic servoOn,
   input wire logic trialRun,
   input wire logic retracting,
   input wire logic forcedPosStop,
   input wire logic [2:0] analysisKind
);
   timeunit 1ns;
   timeprecision 1ps;
   logic forced;
   logic [1:0] expMode;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   assign forced = trialRun | retracting | forcedPosStop;
   always_comb begin
      case (analysisKind)
         3'h2, 3'h4: expMode = 2'h1;
         3'h5: expMode = 2'h2;
         default: expMode = 2'h0;
      endcase
   end
   // Four samples cover the two sync flops and the output register
   sequence forced_s;
      forced [*4];
   endsequence
   sequence analysis_s;
      (!forced && analysisKind inside {[3'h1:3'h5]} && $stable(analysisKind)) [*4];
   endsequence
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not okay");
   limit_copy_a: assert property (speedLimitOut == (speed_match_out && activeMode == 2'h2))
      else $error("limit output differs from match");
   match_gate_a: assert property ((activeMode == 2'h0) [*2] |-> !speed_match_out)
      else $error("match active in position control");
   torque_servo_a: assert property (torqueEnable |-> activeMode == 2'h2)
      else $error("torque enable outside torque mode");
   servo_off_a: assert property ((!servoOn) [*4] |-> !torqueEnable)
      else $error("torque enable without servo on");
   forced_pos_a: assert property (forced_s |-> activeMode == 2'h0)
      else $error("forced position not applied");
   analysis_mode_a: assert property (analysis_s |-> activeMode == expMode)
      else $error("analysis mode wrong");
endmodule // smtm_core_chk
bind smtm_core smtm_core_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .hreadyout(hreadyout),
   .hresp(hresp), .speed_match_out(speed_match_out), .speedLimitOut(speedLimitOut),
   .activeMode(activeMode), .torqueEnable(torqueEnable), .servoOn(servoOn),
   .trialRun(trialRun), .retracting(retracting), .forcedPosStop(forcedPosStop),
   .analysisKind(analysisKind));
`default_nettype wire

// file: verif/speed_match_and_torque_mode_test.sv
// Bench for the speed-match and torque-mode block over AHB-Lite.
// Assumes zero-wait slave and 3-cycle pin to output delay.
`default_nettype none
`include "smtm_cfg.svh"
module speed_match_and_torque_mode_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic servoOn = 0, trialRun = 0, retracting = 0, forcedPosStop = 0, irq;
   logic speed_match_out, speedLimitOut, torqueEnable;
   logic [1:0] htrans = 2'h0, activeMode;
   logic [2:0] analysisKind = 3'h0;
   logic [11:0] haddr = 12'h000;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   logic [15:0] cmdSet = 16'h0, motSet = 16'h0, speedCmd, motorSpeed, speedLimitCmd;
   int num_errors = 0, samples_checked = 0;
   int dv[6] = '{95, 90, 89, 110, 111, -85};
   logic ev[6] = '{0, 0, 1, 1, 0, 1};
   logic [1:0] am[5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
   assign hready = hreadyout;
   initial forever #4 clk_sys = ~clk_sys;
   smtm_plant u_plant (.clk_sys(clk_sys), .cmdSet(cmdSet), .motSet(motSet),
      .speedCmd(speedCmd), .motorSpeed(motorSpeed));
   smtm_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .speedCmd(speedCmd), .motorSpeed(motorSpeed), .servoOn(servoOn), .trialRun(trialRun),
      .retracting(retracting), .forcedPosStop(forcedPosStop), .analysisKind(analysisKind),
      .speed_match_out(speed_match_out), .speedLimitOut(speedLimitOut),
      .activeMode(activeMode), .torqueEnable(torqueEnable), .speedLimitCmd(speedLimitCmd),
      .irq(irq));
   // ************
   // Tasks
   // ************
   task finish_test;
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         finish_test;
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= `SMTM_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      r = hrdata;
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, r);
   endtask
   // One edge past the output update, so the launch edge is not raced
   task settle;
      repeat (5) @(posedge clk_sys);
   endtask
   // ************
   // Main sequence
   // ************
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd("vlim1", `SMTM_OFF_VLIM1, 32'h0);
      rd("vlim2", `SMTM_OFF_VLIM2, 32'h0);
      rd("window", `SMTM_OFF_WIN, 32'h0000000a);
      rd("status", `SMTM_OFF_STAT, 32'h1);
      rd("unmapped", 12'h040, 32'h0);
      xfer(1'b1, `SMTM_OFF_WIN, 32'h5);
      rd("window low", `SMTM_OFF_WIN, 32'h0000000a);
      xfer(1'b1, `SMTM_OFF_WIN, 32'h7530);
      rd("window high", `SMTM_OFF_WIN, 32'h00004e20);
      xfer(1'b1, `SMTM_OFF_WIN, 32'h64);
      motSet <= 16'h03e8;
      cmdSet <= 16'h05dc;
      settle();
      chk("match off", 32'h0, {31'h0, speed_match_out});
      for (int i = 0; i < 6; i++) begin
         cmdSet <= 16'(1000 + dv[i]);
         settle();
         chk("match", {31'h0, ev[i]}, {31'h0, speed_match_out});
      end
      xfer(1'b1, `SMTM_OFF_VLIM1, 32'h1f4);
      xfer(1'b1, `SMTM_OFF_CTRL, 32'h2);
      servoOn <= 1'b1;
      settle();
      chk("mode", 32'h2, {30'h0, activeMode});
      chk("torque en", 32'h1, {31'h0, torqueEnable});
      chk("limit out", 32'h1, {31'h0, speedLimitOut});
      chk("limit cmd", 32'h1f4, {16'h0, speedLimitCmd});
      xfer(1'b1, `SMTM_OFF_VLIM2, 32'h2bc);
      xfer(1'b1, `SMTM_OFF_CTRL, 32'h12);
      servoOn <= 1'b0;
      settle();
      chk("limit cmd 2", 32'h2bc, {16'h0, speedLimitCmd});
      chk("torque off", 32'h0, {31'h0, torqueEnable});
      for (int i = 0; i < 3; i++) begin
         {trialRun, retracting, forcedPosStop} <= 3'h1 << i;
         settle();
         chk("forced", 32'h0, {30'h0, activeMode});
         chk("gated", 32'h0, {31'h0, speed_match_out});
      end
      {trialRun, retracting, forcedPosStop} <= 3'h0;
      for (int k = 1; k <= 5; k++) begin
         analysisKind <= 3'(k);
         settle();
         chk("analysis", {30'h0, am[k-1]}, {30'h0, activeMode});
      end
      analysisKind <= 3'h0;
      settle();
      chk("irq masked", 32'h0, {31'h0, irq});
      xfer(1'b0, `SMTM_OFF_IRQST, 32'h0);
      xfer(1'b1, `SMTM_OFF_IRQMSK, 32'h2);
      xfer(1'b1, `SMTM_OFF_TRQ, 32'h64);
      repeat (2) @(posedge clk_sys);
      chk("irq set", 32'h1, {31'h0, irq});
      rd("irq status", `SMTM_OFF_IRQST, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk("irq clear", 32'h0, {31'h0, irq});
      finish_test();
   end
endmodule // speed_match_and_torque_mode_test
`default_nettype wire
